// ===== hdl/eic_pkg.sv
// constants for the ecc error injection and monitor control block
package eic_pkg;
    // ------------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------------
    localparam int ADDR_W = 20;
    localparam logic [19:0] OFS_INJ_MASK_HI = 20'hFF000;
    localparam logic [19:0] OFS_INJ_MASK_LO = 20'hFF004;
    localparam logic [19:0] OFS_INJ_MASK_PAR = 20'hFF008;
    localparam logic [19:0] OFS_CAP_MON_HI = 20'hFF00C;
    localparam logic [19:0] OFS_CAP_MON_LO = 20'hFF010;
    localparam logic [19:0] OFS_CAP_MON_PAR = 20'hFF014;
    localparam logic [19:0] OFS_MON_CTRL = 20'hFF048;
    // ------------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------------
    localparam int CTL_IRQ_EN = 31;
    localparam int CTL_IRQ_ROUTE = 30;
    localparam int CTL_IRQ_PEND = 29;
    localparam int CTL_RUN = 24;
    localparam int CTL_CNT2_LSB = 16;
    localparam int CTL_CNT1_LSB = 8;
    localparam int CTL_TRIG_LSB = 6;
    localparam int CTL_MODE_LSB = 4;
    localparam int CTL_SEL_LSB = 2;
    localparam int CTL_CONT = 1;
    localparam int CTL_HOLD = 0;
    // writable bits; reserved 28:25, 23:20, 15:12 stay zero
    localparam logic [31:0] CTL_RW_MASK = 32'hC10F0FFF;
    localparam logic [31:0] CTL_RESET = 32'h00000000;
    // ------------------------------------------------------------------
    // parity mask / capture fields
    // ------------------------------------------------------------------
    localparam int PAR_RD_EN = 9;
    localparam int PAR_WR_EN = 8;
    localparam int CAP_FLAG = 8;
    localparam logic [31:0] PAR_MASK_RW = 32'h000003FF;
    // ------------------------------------------------------------------
    // field encodings
    // ------------------------------------------------------------------
    localparam logic [1:0] SEL_MONITOR = 2'h0;
    localparam logic [1:0] SEL_INJECT = 2'h2;
    localparam logic [1:0] TRIG_HIGH = 2'h2;
    localparam logic [1:0] TRIG_LOW = 2'h3;
    // ------------------------------------------------------------------
    // data path sizes
    // ------------------------------------------------------------------
    localparam int DATA_W = 64;
    localparam int CHK_W = 8;
    localparam int SBE_CNT_W = 8;
    localparam logic [7:0] SBE_CNT_MAX = 8'hFF;
endpackage

// ===== hdl/eic_ecc_inject_ctrl.sv
// ecc data path with error injection, capture monitors and monitor control register
`timescale 1ns/100ps

module eic_ecc_inject_ctrl (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [19:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    output logic [31:0] reg_rdata_o,
    output logic reg_rvalid_o,
    input wire logic wr_valid_i,
    input wire logic [63:0] wr_data_i,
    output logic mem_wr_valid_o,
    output logic [63:0] mem_wdata_o,
    output logic [7:0] mem_wcheck_o,
    input wire logic rd_valid_i,
    input wire logic [63:0] mem_rdata_i,
    input wire logic [7:0] mem_rcheck_i,
    output logic rd_valid_o,
    output logic [63:0] rd_data_o,
    output logic sbe_o,
    output logic mbe_o,
    input wire logic [7:0] sbe_threshold_i,
    input wire logic status_clear_i,
    output logic [7:0] sbe_count_o,
    output logic error_status_one_o,
    output logic error_status_two_o,
    input wire logic monitor_event_i,
    input wire logic monitor_trigger_i,
    output logic local_irq_o,
    output logic pci_inta_o,
    output logic monitor_enable_o,
    output logic scan_run_o,
    output logic continuous_scan_select_o,
    output logic trigger_hold_enable_o,
    output logic [3:0] monitor_counter_one_o,
    output logic [3:0] monitor_counter_two_o,
    output logic [1:0] monitor_mode_o,
    output logic trigger_output_pin_o,
    output logic trigger_output_pin_oe_o
);
    // ------------------------------------------------------------------
    // ecc helpers
    // ------------------------------------------------------------------
    // codeword position of data bit i, skipping power-of-two slots
    function automatic logic [6:0] ecc_pos(input int i);
        logic [7:0] p;
        p = 8'h02;
        for (int k = 0; k <= i; k++) begin
            p = p + 8'h01;
            if ((p & (p - 8'h01)) == 8'h00) begin
                p = p + 8'h01;
            end
        end
        return p[6:0];
    endfunction

    // hamming check bits plus overall parity in the top bit
    function automatic logic [7:0] ecc_check(input logic [63:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 0; i < eic_pkg::DATA_W; i++) begin
            c[6:0] = c[6:0] ^ ({7{d[i]}} & ecc_pos(i));
        end
        c[7] = ^{d, c[6:0]};
        return c;
    endfunction

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [31:0] ctrl_reg, ctrl_next;
    logic [31:0] mask_hi_reg, mask_hi_next;
    logic [31:0] mask_lo_reg, mask_lo_next;
    logic [31:0] mask_par_reg, mask_par_next;
    logic [31:0] cap_hi_reg, cap_hi_next;
    logic [31:0] cap_lo_reg, cap_lo_next;
    logic [7:0] cap_chk_reg, cap_chk_next;
    logic cap_flag_reg, cap_flag_next;
    logic [7:0] sbe_cnt_reg, sbe_cnt_next;
    logic stat1_reg, stat1_next;
    logic stat2_reg, stat2_next;
    logic [31:0] rdata_reg, rdata_next;
    logic inj_active, wr_inj, rd_inj;
    logic [63:0] data_mask, rd_masked, rd_fixed;
    logic [7:0] wr_chk_clean, rd_chk_in, rd_chk_calc;
    logic [6:0] syndrome;
    logic par_err, hit_data, sbe_now, mbe_now;

    // ------------------------------------------------------------------
    // injection decode
    // ------------------------------------------------------------------
    // only the exact enabling code arms the masks; reserved codes do nothing
    always_comb begin
        inj_active = (ctrl_reg[eic_pkg::CTL_SEL_LSB +: 2] == eic_pkg::SEL_INJECT);
        wr_inj = inj_active && mask_par_reg[eic_pkg::PAR_WR_EN];
        rd_inj = inj_active && mask_par_reg[eic_pkg::PAR_RD_EN];
        data_mask = {mask_hi_reg, mask_lo_reg};
        monitor_enable_o = (ctrl_reg[eic_pkg::CTL_SEL_LSB +: 2] == eic_pkg::SEL_MONITOR);
    end

    // ------------------------------------------------------------------
    // read checker
    // ------------------------------------------------------------------
    // memory check bits are taken as truth; only a mismatch that points at a data slot is corrected
    always_comb begin
        rd_masked = rd_inj ? (mem_rdata_i ^ data_mask) : mem_rdata_i;
        rd_chk_in = rd_inj ? (mem_rcheck_i ^ mask_par_reg[7:0]) : mem_rcheck_i;
        rd_chk_calc = ecc_check(rd_masked);
        syndrome = rd_chk_calc[6:0] ^ rd_chk_in[6:0];
        par_err = ^{rd_masked, rd_chk_in};
        rd_fixed = rd_masked;
        hit_data = 1'b0;
        for (int i = 0; i < eic_pkg::DATA_W; i++) begin
            if (par_err && (syndrome == ecc_pos(i))) begin
                rd_fixed[i] = ~rd_masked[i];
                hit_data = 1'b1;
            end
        end
        // a check-bit slot cannot map to a data bit, so it falls to multi-bit
        sbe_now = rd_valid_i && hit_data;
        mbe_now = rd_valid_i && !hit_data && (par_err || (syndrome != 7'h00));
        wr_chk_clean = ecc_check(wr_data_i);
    end

    // ------------------------------------------------------------------
    // register file next state
    // ------------------------------------------------------------------
    always_comb begin
        ctrl_next = ctrl_reg;
        mask_hi_next = mask_hi_reg;
        mask_lo_next = mask_lo_reg;
        mask_par_next = mask_par_reg;
        cap_hi_next = cap_hi_reg;
        cap_lo_next = cap_lo_reg;
        cap_chk_next = cap_chk_reg;
        cap_flag_next = cap_flag_reg;
        sbe_cnt_next = sbe_cnt_reg;
        stat1_next = stat1_reg;
        stat2_next = stat2_reg;
        rdata_next = rdata_reg;
        if (reg_wr_i) begin
            unique case (reg_addr_i)
                eic_pkg::OFS_MON_CTRL: begin
                    // pending bit is write-one-to-clear, reserved bits dropped
                    ctrl_next = (reg_wdata_i & eic_pkg::CTL_RW_MASK)
                        | (ctrl_reg & (32'h1 << eic_pkg::CTL_IRQ_PEND));
                    if (reg_wdata_i[eic_pkg::CTL_IRQ_PEND]) begin
                        ctrl_next[eic_pkg::CTL_IRQ_PEND] = 1'b0;
                    end
                end
                eic_pkg::OFS_INJ_MASK_HI: mask_hi_next = reg_wdata_i;
                eic_pkg::OFS_INJ_MASK_LO: mask_lo_next = reg_wdata_i;
                eic_pkg::OFS_INJ_MASK_PAR: mask_par_next = reg_wdata_i & eic_pkg::PAR_MASK_RW;
                eic_pkg::OFS_CAP_MON_PAR: cap_flag_next = reg_wdata_i[eic_pkg::CAP_FLAG];
                default: begin
                end
            endcase
        end
        // event set wins over a same-cycle software clear
        if (monitor_event_i) begin
            ctrl_next[eic_pkg::CTL_IRQ_PEND] = 1'b1;
        end
        if (status_clear_i) begin
            stat1_next = 1'b0;
            stat2_next = 1'b0;
        end
        if (sbe_now) begin
            if (sbe_cnt_reg != eic_pkg::SBE_CNT_MAX) begin
                sbe_cnt_next = sbe_cnt_reg + 8'h01;
            end
            if ((sbe_threshold_i != 8'h00) && (sbe_cnt_next >= sbe_threshold_i)) begin
                stat1_next = 1'b1;
            end
        end
        if (mbe_now) begin
            stat2_next = 1'b1;
        end
        // first failure is kept; a same-cycle flag clear wins and that failure is not captured
        if ((sbe_now || mbe_now) && !cap_flag_reg) begin
            cap_hi_next = rd_masked[63:32];
            cap_lo_next = rd_masked[31:0];
            cap_chk_next = rd_chk_in;
            cap_flag_next = 1'b1;
        end
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                eic_pkg::OFS_MON_CTRL: rdata_next = ctrl_reg;
                eic_pkg::OFS_INJ_MASK_HI: rdata_next = mask_hi_reg;
                eic_pkg::OFS_INJ_MASK_LO: rdata_next = mask_lo_reg;
                eic_pkg::OFS_INJ_MASK_PAR: rdata_next = mask_par_reg;
                eic_pkg::OFS_CAP_MON_HI: rdata_next = cap_hi_reg;
                eic_pkg::OFS_CAP_MON_LO: rdata_next = cap_lo_reg;
                eic_pkg::OFS_CAP_MON_PAR: rdata_next = {23'h0, cap_flag_reg, cap_chk_reg};
                default: rdata_next = 32'h00000000;
            endcase
        end
    end

    // register file and status
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            ctrl_reg <= eic_pkg::CTL_RESET;
            mask_hi_reg <= 32'h00000000;
            mask_lo_reg <= 32'h00000000;
            mask_par_reg <= 32'h00000000;
            cap_hi_reg <= 32'h00000000;
            cap_lo_reg <= 32'h00000000;
            cap_chk_reg <= 8'h00;
            cap_flag_reg <= 1'b0;
            sbe_cnt_reg <= 8'h00;
            stat1_reg <= 1'b0;
            stat2_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            reg_rvalid_o <= 1'b0;
        end else begin
            ctrl_reg <= ctrl_next;
            mask_hi_reg <= mask_hi_next;
            mask_lo_reg <= mask_lo_next;
            mask_par_reg <= mask_par_next;
            cap_hi_reg <= cap_hi_next;
            cap_lo_reg <= cap_lo_next;
            cap_chk_reg <= cap_chk_next;
            cap_flag_reg <= cap_flag_next;
            sbe_cnt_reg <= sbe_cnt_next;
            stat1_reg <= stat1_next;
            stat2_reg <= stat2_next;
            rdata_reg <= rdata_next;
            reg_rvalid_o <= reg_rd_i;
        end
    end

    // ------------------------------------------------------------------
    // data path and trigger pin registers
    // ------------------------------------------------------------------
    // check bits come from clean data; corruption is added afterwards
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            mem_wr_valid_o <= 1'b0;
            mem_wdata_o <= 64'h0000000000000000;
            mem_wcheck_o <= 8'h00;
            rd_valid_o <= 1'b0;
            rd_data_o <= 64'h0000000000000000;
            sbe_o <= 1'b0;
            mbe_o <= 1'b0;
            trigger_output_pin_o <= 1'b0;
            trigger_output_pin_oe_o <= 1'b0;
        end else begin
            mem_wr_valid_o <= wr_valid_i;
            mem_wdata_o <= wr_inj ? (wr_data_i ^ data_mask) : wr_data_i;
            mem_wcheck_o <= wr_inj ? (wr_chk_clean ^ mask_par_reg[7:0]) : wr_chk_clean;
            rd_valid_o <= rd_valid_i;
            rd_data_o <= sbe_now ? rd_fixed : rd_masked;
            sbe_o <= sbe_now;
            mbe_o <= mbe_now;
            trigger_output_pin_oe_o <= ctrl_reg[eic_pkg::CTL_TRIG_LSB + 1];
            trigger_output_pin_o <= (ctrl_reg[eic_pkg::CTL_TRIG_LSB +: 2] == eic_pkg::TRIG_LOW)
                ? ~monitor_trigger_i : monitor_trigger_i;
        end
    end

    // ------------------------------------------------------------------
    // monitor control outputs
    // ------------------------------------------------------------------
    // interrupt lines are plain levels from the control bits
    assign local_irq_o = ctrl_reg[eic_pkg::CTL_IRQ_EN] && ctrl_reg[eic_pkg::CTL_IRQ_PEND]
        && !ctrl_reg[eic_pkg::CTL_IRQ_ROUTE];
    assign pci_inta_o = ctrl_reg[eic_pkg::CTL_IRQ_EN] && ctrl_reg[eic_pkg::CTL_IRQ_PEND]
        && ctrl_reg[eic_pkg::CTL_IRQ_ROUTE];
    assign scan_run_o = ctrl_reg[eic_pkg::CTL_RUN];
    assign continuous_scan_select_o = ctrl_reg[eic_pkg::CTL_CONT];
    assign trigger_hold_enable_o = ctrl_reg[eic_pkg::CTL_HOLD];
    assign monitor_counter_one_o = ctrl_reg[eic_pkg::CTL_CNT1_LSB +: 4];
    assign monitor_counter_two_o = ctrl_reg[eic_pkg::CTL_CNT2_LSB +: 4];
    assign monitor_mode_o = ctrl_reg[eic_pkg::CTL_MODE_LSB +: 2];
    assign reg_rdata_o = rdata_reg;
    assign sbe_count_o = sbe_cnt_reg;
    assign error_status_one_o = stat1_reg;
    assign error_status_two_o = stat2_reg;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);

    wr_passthru_a: assert property (wr_valid_i && !inj_active
        |=> mem_wdata_o == $past(wr_data_i) && mem_wcheck_o == ecc_check($past(wr_data_i)))
        else $error("write data altered while injection off");
    wr_clean_chk_a: assert property (wr_valid_i && wr_inj
        |=> (mem_wcheck_o ^ $past(mask_par_reg[7:0])) == ecc_check($past(wr_data_i)))
        else $error("write check bits not from clean data");
    irq_gate_a: assert property (!ctrl_reg[eic_pkg::CTL_IRQ_EN]
        |-> !local_irq_o && !pci_inta_o)
        else $error("interrupt while disabled");
    irq_route_a: assert property (local_irq_o
        |-> !pci_inta_o && !ctrl_reg[eic_pkg::CTL_IRQ_ROUTE])
        else $error("interrupt on wrong line");
    pend_set_a: assert property (monitor_event_i |=> ctrl_reg[eic_pkg::CTL_IRQ_PEND])
        else $error("pending bit not set by event");
    pend_clear_a: assert property (reg_wr_i && reg_addr_i == eic_pkg::OFS_MON_CTRL
        && reg_wdata_i[eic_pkg::CTL_IRQ_PEND] && !monitor_event_i
        |=> !ctrl_reg[eic_pkg::CTL_IRQ_PEND])
        else $error("pending bit not cleared by write one");
    trig_hiz_a: assert property (!ctrl_reg[eic_pkg::CTL_TRIG_LSB + 1]
        |=> !trigger_output_pin_oe_o)
        else $error("trigger pin driven while disabled");
    sbe_count_a: assert property (rd_valid_o && sbe_o
        |-> sbe_count_o == $past(sbe_count_o) + 8'h01 || $past(sbe_count_o) == 8'hFF)
        else $error("single-bit counter not advanced");
    mbe_raw_a: assert property (mbe_now ##1 1'b1 |-> rd_data_o == $past(rd_masked)
        && error_status_two_o)
        else $error("multi-bit read data changed or status missing");
    cap_hold_a: assert property (cap_flag_reg && !reg_wr_i [*2] |-> $stable(cap_hi_reg)
        && $stable(cap_chk_reg))
        else $error("capture overwritten while flag set");
    rsvd_zero_a: assert property ((ctrl_reg & ~eic_pkg::CTL_RW_MASK
        & ~(32'h1 << eic_pkg::CTL_IRQ_PEND)) == 32'h0)
        else $error("reserved control bits nonzero");

    sbe_seen_c: cover property (rd_valid_i && rd_inj ##1 sbe_o);
    mbe_seen_c: cover property (rd_valid_i && rd_inj ##1 mbe_o);
    wr_inj_c: cover property (wr_valid_i && wr_inj);
    irq_pci_c: cover property (pci_inta_o);
endmodule

// ===== sim/eic_mem_model.sv
// behavioural memory array standing behind the ecc data path
`timescale 1ns/100ps
module eic_mem_model (
    input wire logic clock_i,
    input wire logic mem_wr_valid_i,
    input wire logic [63:0] mem_wdata_i,
    input wire logic [7:0] mem_wcheck_i,
    input wire logic fetch_i,
    output logic rd_valid_o,
    output logic [63:0] rd_data_o,
    output logic [7:0] rd_check_o
);
    logic [63:0] store_reg;
    logic [7:0] check_reg;
    initial begin
        store_reg = 64'h0;
        check_reg = 8'h0;
        rd_valid_o = 1'b0;
        rd_data_o = 64'hFFFFFFFFFFFFFFFF;
        rd_check_o = 8'hFF;
    end
    // one location; keeps beats exactly as sent, check bits included
    always @(posedge clock_i) begin
        if (mem_wr_valid_i) begin
            store_reg <= mem_wdata_i;
            check_reg <= mem_wcheck_i;
        end
        // outside a beat the bus toggles so stale data never looks valid
        rd_valid_o <= #1 fetch_i;
        rd_data_o <= #1 fetch_i ? store_reg : ~rd_data_o;
        rd_check_o <= #1 fetch_i ? check_reg : ~rd_check_o;
    end
endmodule

// ===== sim/tb_top.sv
// register and data path tests for the ecc injection control block
`timescale 1ns/100ps
module tb_top;
    logic clock_i, reset_i, reg_wr_i, reg_rd_i, wr_valid_i, fetch;
    logic [19:0] reg_addr_i;
    logic [31:0] reg_wdata_i, reg_rdata_o, rv;
    logic reg_rvalid_o, mem_wr_valid_o, rd_valid_i, rd_valid_o, sbe_o, mbe_o;
    logic [63:0] wr_data_i, mem_wdata_o, mem_rdata_i, rd_data_o;
    logic [7:0] mem_wcheck_o, mem_rcheck_i, sbe_threshold_i, sbe_count_o;
    logic status_clear_i, st1, st2, monitor_event_i, monitor_trigger_i;
    logic local_irq_o, pci_inta_o, mon_en, pin, pin_oe;
    logic scan_run, cont_sel, hold_en;
    logic [1:0] mon_mode;
    logic [3:0] cnt_one, cnt_two;
    int n_errors = 0;
    int check_count = 0;
    localparam logic [63:0] D = 64'hA5A50F0F3C3C1234;
    eic_ecc_inject_ctrl dut_u (.clock_i(clock_i), .reset_i(reset_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .wr_valid_i(wr_valid_i),
        .wr_data_i(wr_data_i), .mem_wr_valid_o(mem_wr_valid_o), .mem_wdata_o(mem_wdata_o),
        .mem_wcheck_o(mem_wcheck_o), .rd_valid_i(rd_valid_i), .mem_rdata_i(mem_rdata_i),
        .mem_rcheck_i(mem_rcheck_i), .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o),
        .sbe_o(sbe_o), .mbe_o(mbe_o), .sbe_threshold_i(sbe_threshold_i),
        .status_clear_i(status_clear_i), .sbe_count_o(sbe_count_o),
        .error_status_one_o(st1), .error_status_two_o(st2),
        .monitor_event_i(monitor_event_i), .monitor_trigger_i(monitor_trigger_i),
        .local_irq_o(local_irq_o), .pci_inta_o(pci_inta_o), .monitor_enable_o(mon_en),
        .scan_run_o(scan_run), .continuous_scan_select_o(cont_sel),
        .trigger_hold_enable_o(hold_en), .monitor_counter_one_o(cnt_one),
        .monitor_counter_two_o(cnt_two), .monitor_mode_o(mon_mode),
        .trigger_output_pin_o(pin), .trigger_output_pin_oe_o(pin_oe));
    eic_mem_model mem_u (.clock_i(clock_i), .mem_wr_valid_i(mem_wr_valid_o),
        .mem_wdata_i(mem_wdata_o), .mem_wcheck_i(mem_wcheck_o), .fetch_i(fetch),
        .rd_valid_o(rd_valid_i), .rd_data_o(mem_rdata_i), .rd_check_o(mem_rcheck_i));
    // ----------------------------------------------------------------
    // clock, helpers
    // ----------------------------------------------------------------
    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end
    // reference code: data bit i sits at the i-th non-power-of-two slot
    function automatic logic [7:0] ecc(input logic [63:0] d);
        logic [6:0] s;
        int p;
        s = 7'h0;
        p = 3;
        for (int i = 0; i < 64; i++) begin
            while ((p & (p - 1)) == 0) p++;
            if (d[i]) s ^= p[6:0];
            p++;
        end
        return {^d ^ ^s, s};
    endfunction
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [19:0] a, input logic [31:0] d);
        @(posedge clock_i) #1 {reg_wr_i, reg_addr_i, reg_wdata_i} = {1'b1, a, d};
        @(posedge clock_i) #1 reg_wr_i = 1'b0;
    endtask
    // the answer stands one cycle, so look straight after the taking edge
    task automatic rd(input logic [19:0] a, input logic [31:0] exp);
        @(posedge clock_i) #1 {reg_rd_i, reg_addr_i} = {1'b1, a};
        @(posedge clock_i) #1 reg_rd_i = 1'b0;
        chk({63'h0, reg_rvalid_o}, 64'h1);
        chk({32'h0, reg_rdata_o}, {32'h0, exp});
    endtask
    task automatic beat_wr(input logic [63:0] exp_d);
        @(posedge clock_i) #1 {wr_valid_i, wr_data_i} = {1'b1, D};
        @(posedge clock_i) #1 wr_valid_i = 1'b0;
        chk({63'h0, mem_wr_valid_o}, 64'h1);
        chk(mem_wdata_o, exp_d);
        chk({56'h0, mem_wcheck_o}, {56'h0, ecc(D)});
    endtask
    task automatic beat_rd(input logic s, input logic m);
        @(posedge clock_i) #1 fetch = 1'b1;
        @(posedge clock_i) #1 fetch = 1'b0;
        @(posedge clock_i) #1;
        chk({63'h0, rd_valid_o}, 64'h1);
        chk(rd_data_o, D);
        chk({62'h0, sbe_o, mbe_o}, {62'h0, s, m});
    endtask
    task automatic finish_test();
        $display("checks=%0d errors=%0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        #200000;
        n_errors++;
        finish_test();
    end
    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        {reset_i, reg_wr_i, reg_rd_i, wr_valid_i, fetch, status_clear_i} = 6'h20;
        {monitor_event_i, monitor_trigger_i} = 2'h0;
        {reg_addr_i, reg_wdata_i, wr_data_i} = '0;
        sbe_threshold_i = 8'h01;
        repeat (5) @(posedge clock_i);
        #1 reset_i = 1'b0;
        chk({63'h0, mon_en}, 64'h1);
        // monitor control fields all come out of reset cleared
        chk({51'h0, scan_run, cont_sel, hold_en, mon_mode, cnt_one, cnt_two}, 64'h0);
        rd(eic_pkg::OFS_MON_CTRL, 32'h00000000);
        rd(20'hFF040, 32'h00000000);
        wr(eic_pkg::OFS_MON_CTRL, 32'hFFFFFFFF);
        rd(eic_pkg::OFS_MON_CTRL, 32'hC10F0FFF);
        chk({51'h0, scan_run, cont_sel, hold_en, mon_mode, cnt_one, cnt_two}, 64'h1FFF);
        chk({63'h0, mon_en}, 64'h0);
        $display("register test done");
        // every trigger drive code with a raised trigger
        monitor_trigger_i = 1'b1;
        for (int c = 0; c < 4; c++) begin
            wr(eic_pkg::OFS_MON_CTRL, 32'(c) << 6);
            @(posedge clock_i) #1;
            chk({63'h0, pin_oe}, {63'h0, c[1]});
            if (c[1]) chk({63'h0, pin}, {63'h0, ~c[0]});
        end
        $display("trigger test done");
        wr(eic_pkg::OFS_MON_CTRL, 32'h00000000);
        // writing zero stops the scan and drops continuous select, hold, mode and counts
        chk({51'h0, scan_run, cont_sel, hold_en, mon_mode, cnt_one, cnt_two}, 64'h0);
        @(posedge clock_i) #1 monitor_event_i = 1'b1;
        @(posedge clock_i) #1 monitor_event_i = 1'b0;
        rd(eic_pkg::OFS_MON_CTRL, 32'h20000000);
        chk({62'h0, local_irq_o, pci_inta_o}, 64'h0);
        wr(eic_pkg::OFS_MON_CTRL, 32'h80000000);
        chk({62'h0, local_irq_o, pci_inta_o}, 64'h2);
        wr(eic_pkg::OFS_MON_CTRL, 32'hC0000000);
        chk({62'h0, local_irq_o, pci_inta_o}, 64'h1);
        wr(eic_pkg::OFS_MON_CTRL, 32'hE0000000);
        rd(eic_pkg::OFS_MON_CTRL, 32'hC0000000);
        $display("interrupt test done");
        // write path: inject, then two ways of leaving data untouched
        wr(eic_pkg::OFS_MON_CTRL, 32'h00000008);
        wr(eic_pkg::OFS_INJ_MASK_PAR, 32'h00000100);
        wr(eic_pkg::OFS_INJ_MASK_HI, 32'h00000001);
        beat_wr(D ^ 64'h0000000100000000);
        wr(eic_pkg::OFS_MON_CTRL, 32'h00000000);
        beat_wr(D);
        wr(eic_pkg::OFS_MON_CTRL, 32'h00000008);
        wr(eic_pkg::OFS_INJ_MASK_PAR, 32'h00000000);
        beat_wr(D);
        $display("write path test done");
        // read path: memory now holds clean data and clean check bits
        wr(eic_pkg::OFS_CAP_MON_PAR, 32'h00000000);
        wr(eic_pkg::OFS_INJ_MASK_HI, 32'h00000000);
        wr(eic_pkg::OFS_INJ_MASK_LO, 32'h00000020);
        beat_rd(1'b0, 1'b0);
        wr(eic_pkg::OFS_INJ_MASK_PAR, 32'h00000200);
        beat_rd(1'b1, 1'b0);
        chk({56'h0, sbe_count_o}, 64'h1);
        chk({62'h0, st1, st2}, 64'h2);
        rd(eic_pkg::OFS_CAP_MON_LO, D[31:0] ^ 32'h00000020);
        rd(eic_pkg::OFS_CAP_MON_HI, D[63:32]);
        rd(eic_pkg::OFS_CAP_MON_PAR, {23'h0, 1'b1, ecc(D)});
        wr(eic_pkg::OFS_INJ_MASK_LO, 32'h00000000);
        wr(eic_pkg::OFS_INJ_MASK_PAR, 32'h00000201);
        beat_rd(1'b0, 1'b1);
        chk({56'h0, sbe_count_o}, 64'h1);
        chk({62'h0, st1, st2}, 64'h3);
        rd(eic_pkg::OFS_CAP_MON_LO, D[31:0] ^ 32'h00000020);
        @(posedge clock_i) #1 status_clear_i = 1'b1;
        @(posedge clock_i) #1 status_clear_i = 1'b0;
        chk({62'h0, st1, st2}, 64'h0);
        $display("read path test done");
        finish_test();
    end
endmodule
